// *** logic/rrlc_pkg.sv ***
// rrlc_pkg: register map, field positions and encodings for the reference ladder control
// assumes: 32-bit classic wishbone slave, byte addresses, one register per aligned word
package rrlc_pkg;
   // ************************************************
   // register offsets (byte addresses)
   // ************************************************
   localparam logic [3:0] RRLC_ADDR_CONTROL = 4'h0;
   localparam logic [3:0] RRLC_ADDR_LEVEL   = 4'h4;
   localparam logic [3:0] RRLC_ADDR_STATUS  = 4'h8;

   // ************************************************
   // field positions
   // ************************************************
   localparam int RRLC_BIT_ENABLE = 7;
   localparam int RRLC_BIT_LPS    = 6;
   localparam int RRLC_BIT_PINOE  = 5;
   localparam int RRLC_BIT_PSS_HI = 3;
   localparam int RRLC_BIT_PSS_LO = 2;
   localparam int RRLC_BIT_NSS    = 0;
   localparam int RRLC_LEVEL_W    = 5;
   localparam int RRLC_TAPS       = 32;

   // writable bit masks; other bits read zero
   localparam logic [7:0] RRLC_CONTROL_MASK = 8'hed;
   localparam logic [7:0] RRLC_LEVEL_MASK   = 8'h1f;
   localparam logic [7:0] RRLC_RESET_VALUE  = 8'h00;

   localparam logic [4:0] RRLC_LEVEL_MAX  = 5'h1f;
   localparam logic [4:0] RRLC_LEVEL_MIN  = 5'h00;

   // ************************************************
   // source selects
   // ************************************************
   typedef enum logic [1:0] {
      RRLC_PSRC_SUPPLY   = 2'b00,
      RRLC_PSRC_EXTREF   = 2'b01,
      RRLC_PSRC_FIXEDREF = 2'b10,
      RRLC_PSRC_RESERVED = 2'b11
   } rrlc_psrc_e;
endpackage

// *** logic/rrlc_tap_decoder.sv ***
// rrlc_tap_decoder: one-hot tap select of the ladder from the level code
// assumes: level code already registered on clk_i; output registered here
`timescale 1ns/100ps
module rrlc_tap_decoder (
   input  wire logic                                clk_i,
   input  wire logic                                rst_i,
   input  wire logic                                active_i,
   input  wire logic [rrlc_pkg::RRLC_LEVEL_W-1:0]   level_i,
   output logic      [rrlc_pkg::RRLC_TAPS-1:0]      tap_sel_o
);
   // one tap per code, none while the ladder is idle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tap_sel_o <= '0;
      end else begin
         for (int i = 0; i < rrlc_pkg::RRLC_TAPS; i++) begin
            tap_sel_o[i] <= active_i && (level_i == i[rrlc_pkg::RRLC_LEVEL_W-1:0]);
         end
      end
   end
endmodule // rrlc_tap_decoder

// *** logic/rrlc_ladder_control.sv ***
// rrlc_ladder_control: control logic of the 32-level ratiometric reference ladder
// assumes: classic wishbone master on clk_i, synchronous active-high reset, analog ladder outside
// Function
// [RULE1] thirty-two levels chosen by five-bit level code in level register
// [RULE2] ladder active only while enable bit is one
// [RULE3] enabled: tap at code gives negative plus difference times code over 32
// [RULE4] disabled, low-power side one, code all ones: output is positive source
// [RULE5] disabled, low-power side zero, code zero: output is negative source
// [RULE6] low-power side one cuts negative source, zero cuts positive source
// [RULE7] pin enable bit routes reference onto the output pin
// [RULE8] while routed, pin digital driver off and input detector disabled
// [RULE9] digital read of the routed pin returns zero
// [RULE10] software clamps high: enable off, side one, positive source, code all ones
// [RULE11] software clamps low: enable off, side zero, negative source, code zero
// [RULE12] wake from sleep leaves control register unchanged
// [RULE13] software should disable reference before sleep
// [RULE14] reset disables ladder, removes pin route, clears level code
// [RULE15] reference offered to comparator, converter, pin and capacitive sensing
// [RULE16] control bits: enable 7, side 6, pin 5, positive 3-2, negative 0
// [RULE17] positive select: supply, external ref, fixed ref, eleven reserved
// [RULE18] unimplemented bits ignored, new settings act from next clock
`timescale 1ns/100ps
module rrlc_ladder_control (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   output logic             err_o,
   // sleep and pin
   input  wire logic        wake_i,
   input  wire logic        pin_i,
   output logic             pin_dig_in_o,
   output logic             pin_drv_off_o,
   output logic             pin_detect_off_o,
   output logic             pin_analog_o,
   // ladder controls
   output logic [31:0]      tap_sel_o,
   output logic             ladder_active_o,
   output logic             pos_connect_o,
   output logic             neg_connect_o,
   output logic             pos_sel_supply_o,
   output logic             pos_sel_extref_o,
   output logic             pos_sel_fixedref_o,
   output logic             neg_sel_extref_o,
   output logic             clamp_pos_o,
   output logic             clamp_neg_o,
   output logic             ref_to_comparator_o,
   output logic             ref_to_converter_o,
   output logic             ref_to_capsense_o
);
   // ************************************************
   // registers
   // ************************************************
   logic [7:0]  control_q;
   logic [7:0]  level_q;
   logic        req;
   logic        hit;
   logic        wr_control;
   logic        wr_level;
   logic        rd_req;
   logic        pin_meta_q;
   logic        pin_sync_q;
   logic        enable;
   logic        lps;
   logic        pin_oe;
   logic        nss;
   logic [1:0]  pss;
   logic [4:0]  code;
   logic [5:0]  status_w;
   logic [31:0] rdata_d;

   // request decode; a request is taken once, while no answer stands
   assign req    = cyc_i && stb_i && !ack_o && !err_o;
   assign hit    = (adr_i == rrlc_pkg::RRLC_ADDR_CONTROL) || (adr_i == rrlc_pkg::RRLC_ADDR_LEVEL)
                   || (adr_i == rrlc_pkg::RRLC_ADDR_STATUS);
   assign enable = control_q[rrlc_pkg::RRLC_BIT_ENABLE];
   assign lps    = control_q[rrlc_pkg::RRLC_BIT_LPS];
   assign pin_oe = control_q[rrlc_pkg::RRLC_BIT_PINOE];
   assign nss    = control_q[rrlc_pkg::RRLC_BIT_NSS];
   assign pss    = control_q[rrlc_pkg::RRLC_BIT_PSS_HI:rrlc_pkg::RRLC_BIT_PSS_LO];
   assign code   = level_q[rrlc_pkg::RRLC_LEVEL_W-1:0];

   // write strobes; the eight-bit registers sit in byte lane zero only
   assign wr_control = req && we_i && sel_i[0] && (adr_i == rrlc_pkg::RRLC_ADDR_CONTROL);
   assign wr_level   = req && we_i && sel_i[0] && (adr_i == rrlc_pkg::RRLC_ADDR_LEVEL);
   assign rd_req     = req && !we_i;

   // status word: live view of the ladder controls, read only
   assign status_w = {clamp_neg_o, clamp_pos_o, pin_analog_o, neg_connect_o, pos_connect_o, ladder_active_o};

   // ************************************************
   // software registers
   // ************************************************
   // control register; a wake from sleep has no path into it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         control_q <= rrlc_pkg::RRLC_RESET_VALUE; // RULE14
      end else if (wr_control) begin
         control_q <= dat_i[7:0] & rrlc_pkg::RRLC_CONTROL_MASK; // RULE16 RULE18
      end
   end // RULE12

   // level register; bits above the five-bit code are dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_q <= rrlc_pkg::RRLC_RESET_VALUE; // RULE14
      end else if (wr_level) begin
         level_q <= dat_i[7:0] & rrlc_pkg::RRLC_LEVEL_MASK; // RULE1 RULE18
      end
   end

   // ************************************************
   // bus answer
   // ************************************************
   // read multiplexer; unmapped addresses and unimplemented bits read zero
   always_comb begin
      rdata_d = '0;
      case (adr_i)
         rrlc_pkg::RRLC_ADDR_CONTROL: rdata_d = {24'h000000, control_q}; // RULE16
         rrlc_pkg::RRLC_ADDR_LEVEL:   rdata_d = {24'h000000, level_q}; // RULE1
         rrlc_pkg::RRLC_ADDR_STATUS:  rdata_d = {26'h0000000, status_w};
         default:                     rdata_d = '0;
      endcase
   end

   // ack or err one cycle after the request is taken, each for one cycle only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
      end else begin
         ack_o <= req && hit;
         err_o <= req && !hit; // RULE18
      end
   end

   // read data stands with the answer and is zero otherwise
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= '0;
      end else begin
         dat_o <= rd_req ? rdata_d : '0;
      end
   end

   // ************************************************
   // pin handling
   // ************************************************
   // two-stage synchroniser; only the second stage is read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_meta_q <= 1'b0;
         pin_sync_q <= 1'b0;
      end else begin
         pin_meta_q <= pin_i;
         pin_sync_q <= pin_meta_q;
      end
   end

   // reference route onto the pin and override of its digital buffers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_analog_o     <= 1'b0; // RULE14
         pin_drv_off_o    <= 1'b0;
         pin_detect_off_o <= 1'b0;
      end else begin
         pin_analog_o     <= pin_oe; // RULE7
         pin_drv_off_o    <= pin_oe; // RULE8
         pin_detect_off_o <= pin_oe; // RULE8
      end
   end

   // digital read of the pin; a routed pin reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_dig_in_o <= 1'b0;
      end else begin
         pin_dig_in_o <= pin_oe ? 1'b0 : pin_sync_q; // RULE9
      end
   end

   // ************************************************
   // ladder controls
   // ************************************************
   // ladder current flows only while enabled
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ladder_active_o <= 1'b0;
      end else begin
         ladder_active_o <= enable; // RULE2
      end
   end

   // positive source stays connected while enabled or clamped high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pos_connect_o <= 1'b0;
      end else begin
         pos_connect_o <= enable || lps; // RULE6
      end
   end

   // negative source stays connected while enabled or clamped low
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         neg_connect_o <= 1'b0;
      end else begin
         neg_connect_o <= enable || !lps; // RULE6
      end
   end

   // positive source select; the reserved code connects no source
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pos_sel_supply_o   <= 1'b0;
         pos_sel_extref_o   <= 1'b0;
         pos_sel_fixedref_o <= 1'b0;
      end else begin
         pos_sel_supply_o   <= 1'b0;
         pos_sel_extref_o   <= 1'b0;
         pos_sel_fixedref_o <= 1'b0;
         case (pss)
            rrlc_pkg::RRLC_PSRC_SUPPLY:   pos_sel_supply_o   <= 1'b1; // RULE17
            rrlc_pkg::RRLC_PSRC_EXTREF:   pos_sel_extref_o   <= 1'b1; // RULE17
            rrlc_pkg::RRLC_PSRC_FIXEDREF: pos_sel_fixedref_o <= 1'b1; // RULE17
            default:                      pos_sel_supply_o   <= 1'b0; // reserved code
         endcase
      end
   end

   // negative source select: external reference when set, ground otherwise
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         neg_sel_extref_o <= 1'b0;
      end else begin
         neg_sel_extref_o <= nss;
      end
   end

   // output held at the positive source with the ladder off
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clamp_pos_o <= 1'b0;
      end else begin
         clamp_pos_o <= !enable && lps && (code == rrlc_pkg::RRLC_LEVEL_MAX); // RULE4
      end
   end

   // output held at the negative source with the ladder off
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clamp_neg_o <= 1'b0;
      end else begin
         clamp_neg_o <= !enable && !lps && (code == rrlc_pkg::RRLC_LEVEL_MIN); // RULE5
      end
   end

   // ************************************************
   // reference fan-out
   // ************************************************
   // comparator positive input
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_to_comparator_o <= 1'b0;
      end else begin
         ref_to_comparator_o <= 1'b1; // RULE15
      end
   end

   // converter input channel
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_to_converter_o <= 1'b0;
      end else begin
         ref_to_converter_o <= 1'b1; // RULE15
      end
   end

   // capacitive sensing module
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_to_capsense_o <= 1'b0;
      end else begin
         ref_to_capsense_o <= 1'b1; // RULE15
      end
   end

   // tap select: code/32 of the span above the negative source
   rrlc_tap_decoder rrlc_tap_decoder_i (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .active_i  (enable),
      .level_i   (code),
      .tap_sel_o (tap_sel_o)
   ); // RULE3

   // ************************************************
   // sleep
   // ************************************************
   // a wake event reaches no register, so settings survive sleep
   logic unused_wake;
   assign unused_wake = wake_i; // sleep exit does not touch settings
endmodule // rrlc_ladder_control

// *** tb/rrlc_ladder_control_monitor.sv ***
// checker of the reference ladder control ports
// assumes: bound to rrlc_ladder_control, one clock, synchronous reset
`timescale 1ns/100ps
module rrlc_ladder_control_monitor (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [3:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic        ack_o,
   input wire logic        err_o,
   input wire logic        wake_i,
   input wire logic        pin_dig_in_o,
   input wire logic        pin_drv_off_o,
   input wire logic        pin_detect_off_o,
   input wire logic        pin_analog_o,
   input wire logic [31:0] tap_sel_o,
   input wire logic        ladder_active_o,
   input wire logic        pos_connect_o,
   input wire logic        neg_connect_o,
   input wire logic        clamp_pos_o
);
   // ************************************************
   // bus answers and ladder relations
   // ************************************************
   wire logic mapped_w = (adr_i == rrlc_pkg::RRLC_ADDR_CONTROL) || (adr_i == rrlc_pkg::RRLC_ADDR_LEVEL)
                         || (adr_i == rrlc_pkg::RRLC_ADDR_STATUS);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // a request the slave takes, and a write to the control register
   sequence s_take; cyc_i && stb_i && !ack_o && !err_o; endsequence
   sequence s_ctl_wr; s_take ##0 (we_i && sel_i[0] && adr_i == rrlc_pkg::RRLC_ADDR_CONTROL); endsequence
   a_ack_mapped: assert property (s_take ##0 mapped_w |=> ack_o && !err_o)
      else $error("mapped access not acked");
   a_err_unmapped: assert property (s_take ##0 !mapped_w |=> err_o && !ack_o)
      else $error("unmapped access not refused");
   a_enable_applies: assert property (s_ctl_wr ##0 dat_i[7] |=> ##1 ladder_active_o && pos_connect_o && neg_connect_o)
      else $error("enable write not applied");
   a_disable_applies: assert property (s_ctl_wr ##0 !dat_i[7] |=> ##1 !ladder_active_o && tap_sel_o == 32'h0)
      else $error("disable write not applied");
   a_tap_onehot: assert property ($onehot0(tap_sel_o) && (ladder_active_o || tap_sel_o == 32'h0))
      else $error("tap select not one-hot or idle");
   a_side_cuts: assert property (!ladder_active_o && !$past(rst_i) |-> pos_connect_o != neg_connect_o)
      else $error("low-power side not cutting one source");
   a_clamp_side: assert property (clamp_pos_o |-> !ladder_active_o && pos_connect_o && !neg_connect_o)
      else $error("positive clamp with wrong connections");
   a_pin_override: assert property (pin_analog_o |-> pin_drv_off_o && pin_detect_off_o && !pin_dig_in_o)
      else $error("routed pin not overridden");
   a_wake_keeps: assert property (wake_i && !cyc_i && !ack_o |=> $stable(ladder_active_o) && $stable(pin_analog_o))
      else $error("wake changed settings");
endmodule // rrlc_ladder_control_monitor

bind rrlc_ladder_control rrlc_ladder_control_monitor rrlc_ladder_control_monitor_i (.clk_i, .rst_i, .cyc_i, .stb_i,
   .we_i, .adr_i, .sel_i, .dat_i, .ack_o, .err_o, .wake_i, .pin_dig_in_o, .pin_drv_off_o, .pin_detect_off_o,
   .pin_analog_o, .tap_sel_o, .ladder_active_o, .pos_connect_o, .neg_connect_o, .clamp_pos_o);

// *** tb/rrlc_ladder_control_tb.sv ***
// self-checking bench of the reference ladder control
// assumes: package, design and checker compiled first
`timescale 1ns/100ps
module rrlc_ladder_control_tb;
   logic        clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0, wake_i = 1'h0, pin_i = 1'h0, er;
   logic [3:0]  adr_i = 4'h0, sel_i = 4'hf;
   logic [31:0] dat_i = 32'h0, dat_o, tap_sel_o, rd;
   logic        ack_o, err_o, pin_dig_in_o, pin_drv_off_o, pin_detect_off_o, pin_analog_o, ladder_active_o;
   logic        pos_connect_o, neg_connect_o, pos_sel_supply_o, pos_sel_extref_o, pos_sel_fixedref_o, neg_sel_extref_o;
   logic        clamp_pos_o, clamp_neg_o, ref_to_comparator_o, ref_to_converter_o, ref_to_capsense_o;
   int          n_errors = 0, checks = 0;
   // 100 MHz clock
   always #5 clk_i = ~clk_i;
   rrlc_ladder_control rrlc_ladder_control_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
      .ack_o, .err_o, .wake_i, .pin_i, .pin_dig_in_o, .pin_drv_off_o, .pin_detect_off_o, .pin_analog_o, .tap_sel_o,
      .ladder_active_o, .pos_connect_o, .neg_connect_o, .pos_sel_supply_o, .pos_sel_extref_o, .pos_sel_fixedref_o,
      .neg_sel_extref_o, .clamp_pos_o, .clamp_neg_o, .ref_to_comparator_o, .ref_to_converter_o, .ref_to_capsense_o);
   // ************************************************
   // shared tasks
   // ************************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one classic cycle; holds the request until ack or err is sampled, the watchdog ends a hang
   task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d, input logic [3:0] s = 4'hf);
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {1'h1, 1'h1, w, a, d, s};
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'h1 && err_o !== 1'h1);
      rd = dat_o;
      er = err_o;
      {cyc_i, stb_i, we_i} <= 3'h0;
   endtask
   task automatic settle();
      repeat (4) @(posedge clk_i);
      #1;
   endtask
   task automatic do_reset();
      @(posedge clk_i);
      rst_i <= 1'h1;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'h0;
   endtask
   // ************************************************
   // scenarios
   // ************************************************
   task automatic t_reset();
      wb(4'h0, 1'h1, 32'ha0);
      wb(4'h4, 1'h1, 32'h0a);
      do_reset();
      wb(4'h0, 1'h0, 32'h0);
      chk("control", 32'h0, rd);
      wb(4'h4, 1'h0, 32'h0);
      chk("level", 32'h0, rd);
      wb(4'h8, 1'h0, 32'h0);
      chk("status", 32'h24, rd);
      chk("routes", 32'h7, 32'({ref_to_comparator_o, ref_to_converter_o, ref_to_capsense_o}));
      $display("test reset done");
   endtask
   task automatic t_regs();
      wb(4'h0, 1'h1, 32'hffffffff);
      wb(4'h0, 1'h0, 32'h0);
      chk("control mask", 32'hed, rd);
      wb(4'h0, 1'h1, 32'h0, 4'he);
      wb(4'h0, 1'h0, 32'h0);
      chk("lane zero off", 32'hed, rd);
      wb(4'h4, 1'h1, 32'hffffffff);
      wb(4'h4, 1'h0, 32'h0);
      chk("level mask", 32'h1f, rd);
      wb(4'hc, 1'h0, 32'h0);
      chk("unmapped err", 32'h1, 32'(er));
      $display("test registers done");
   endtask
   task automatic t_taps();
      wb(4'h0, 1'h1, 32'h80);
      settle();
      chk("ladder on", 32'h7, 32'({ladder_active_o, pos_connect_o, neg_connect_o}));
      for (int i = 0; i < 32; i++) begin
         wb(4'h4, 1'h1, 32'(i));
         settle();
         chk("tap", 32'h1 << i, tap_sel_o);
      end
      wb(4'h0, 1'h1, 32'h0);
      settle();
      chk("tap off", 32'h0, tap_sel_o);
      chk("ladder off", 32'h1, 32'({ladder_active_o, pos_connect_o, neg_connect_o}));
      $display("test taps done");
   endtask
   task automatic t_clamp();
      for (int p = 0; p < 4; p++) begin
         wb(4'h0, 1'h1, 32'h40 | 32'(p << 2));
         wb(4'h4, 1'h1, 32'h1f);
         settle();
         chk("clamp high", 32'({3'h6, (p == 3) ? 3'h0 : 3'(1 << p)}), 32'({clamp_pos_o, pos_connect_o,
             neg_connect_o, pos_sel_fixedref_o, pos_sel_extref_o, pos_sel_supply_o}));
      end
      wb(4'h0, 1'h1, 32'h1);
      wb(4'h4, 1'h1, 32'h0);
      settle();
      chk("clamp low", 32'hd, 32'({clamp_neg_o, neg_connect_o, pos_connect_o, neg_sel_extref_o}));
      $display("test clamps done");
   endtask
   task automatic t_pin();
      wb(4'h0, 1'h1, 32'h20);
      @(posedge clk_i);
      pin_i <= 1'h1;
      wake_i <= 1'h1;
      @(posedge clk_i);
      wake_i <= 1'h0;
      settle();
      chk("pin routed", 32'he, 32'({pin_analog_o, pin_drv_off_o, pin_detect_off_o, pin_dig_in_o}));
      wb(4'h0, 1'h0, 32'h0);
      chk("after wake", 32'h20, rd);
      wb(4'h0, 1'h1, 32'h0);
      settle();
      chk("pin digital", 32'h1, 32'(pin_dig_in_o));
      $display("test pin done");
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // main sequence and watchdog
   initial begin
      do_reset();
      t_reset();
      t_regs();
      t_taps();
      t_clamp();
      t_pin();
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      stop_test();
   end
endmodule // rrlc_ladder_control_tb
